// file: rtl/sysctl_pkg.sv
// package of register offsets, field positions, reset values and state codes for the system control block
package sysctl_pkg;
  localparam logic [7:0] OFS_COMMON_BASE = 8'h38;
  localparam logic [7:0] OFS_BANK_BASE = 8'h39;
  localparam logic [7:0] OFS_AREA_BOUNDARY = 8'h3A;
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h3E;
  localparam logic [7:0] OFS_IO_CONTROL = 8'h3F;
  localparam logic [5:0] IO_LOCAL_MASK = 6'h3F;
  localparam logic [7:0] RST_COMMON_BASE = 8'h00;
  localparam logic [7:0] RST_BANK_BASE = 8'h00;
  localparam logic [7:0] RST_AREA_BOUNDARY = 8'hFF;
  localparam logic [7:0] RST_MODE_CONTROL = 8'h80;
  localparam logic [7:0] RST_IO_CONTROL = 8'h00;
  localparam int MARKER_ENABLE_BIT = 7;
  localparam int IO_HALT_BIT = 5;
  localparam int IO_RELOC_HI_BIT = 7;
  localparam int IO_RELOC_LO_BIT = 6;
  localparam int COMMON1_START_HI = 7;
  localparam int COMMON1_START_LO = 4;
  localparam int BANK_START_HI = 3;
  localparam int BANK_START_LO = 0;
  localparam int PAGE_SHIFT = 12;
  localparam int NUM_REGS = 5;
  typedef enum logic [2:0] {
    AREA_COMMON0 = 3'b001,
    AREA_BANK = 3'b010,
    AREA_COMMON1 = 3'b100
  } area_t;
  typedef enum logic [2:0] {
    FETCH_IDLE = 3'b001,
    FETCH_NORMAL = 3'b010,
    FETCH_LEGACY = 3'b100
  } fetch_state_t;
endpackage

// file: rtl/reg_word.sv
// one control register with synchronous reset value and write strobe
`timescale 1ns/1ns
`default_nettype none
module reg_word #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic wr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] q_out
);
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      q_out <= RESET_VAL;
    end else if (wr_in) begin
      q_out <= data_in;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sysctl_regs.sv
// memory mapping, fetch-marker mode and internal i/o control registers
`timescale 1ns/1ns
`default_nettype none
// Function
// - bank base holds a 4 KB page base used for bank area accesses
// - reset clears bank base to zero
// - boundary register splits 64 KB logical space into up to three areas
// - upper nibble is first page of common area 1
// - lower nibble is first page of bank area
// - reset sets both boundary nibbles to all ones
// - marker enable set by reset; marker low on fetch, irq0 ack, nmi first cycle
// - marker enable one: return-from-interrupt fetched once only
// - marker enable zero: marker not driven low on instruction fetch
// - marker enable zero: return-from-interrupt refetched with legacy marker cycle
// - two relocation bits place the internal i/o block
// - internal i/o decodes only when upper address byte is zero
// - reset clears both relocation bits
// - i/o halt bit enables i/o stop mode until cleared or reset
// - common base, cleared by reset, forms 20-bit address for common area 1
module sysctl_regs (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_hit_out,
  input wire logic [15:0] log_addr_in,
  output logic [19:0] phys_addr_out,
  output logic [2:0] area_out,
  input wire logic opcode_fetch_in,
  input wire logic irq0_ack_in,
  input wire logic nmi_ack_first_in,
  input wire logic return_from_interrupt_instr_fetched_in,
  output logic cycle_marker_out_n,
  output logic return_from_interrupt_instr_refetch_out,
  output logic io_halt_mode_out,
  output logic [7:0] io_block_base_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
    logic [19:0] phys;
    logic [2:0] area;
    logic marker_n;
    sysctl_pkg::fetch_state_t fetch;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [7:0] regs [sysctl_pkg::NUM_REGS];
  logic [7:0] reg_ofs [sysctl_pkg::NUM_REGS];
  logic [7:0] reg_rst [sysctl_pkg::NUM_REGS];
  logic [sysctl_pkg::NUM_REGS-1:0] wr_sel;
  logic [7:0] local_ofs;
  logic in_block;
  logic [3:0] page;
  logic [3:0] common1_start;
  logic [3:0] bank_start;
  logic marker_en;
  logic [7:0] sel_base;
  logic [7:0] common_base_reg;
  logic [7:0] bank_base_reg;
  logic [7:0] area_boundary_reg;
  logic [7:0] mode_control_reg;
  logic [7:0] io_control_reg;

  assign reg_ofs[0] = sysctl_pkg::OFS_COMMON_BASE;
  assign reg_ofs[1] = sysctl_pkg::OFS_BANK_BASE;
  assign reg_ofs[2] = sysctl_pkg::OFS_AREA_BOUNDARY;
  assign reg_ofs[3] = sysctl_pkg::OFS_MODE_CONTROL;
  assign reg_ofs[4] = sysctl_pkg::OFS_IO_CONTROL;
  assign reg_rst[0] = sysctl_pkg::RST_COMMON_BASE;
  assign reg_rst[1] = sysctl_pkg::RST_BANK_BASE;
  assign reg_rst[2] = sysctl_pkg::RST_AREA_BOUNDARY;
  assign reg_rst[3] = sysctl_pkg::RST_MODE_CONTROL;
  assign reg_rst[4] = sysctl_pkg::RST_IO_CONTROL;

  assign common_base_reg = regs[0];
  assign bank_base_reg = regs[1];
  assign area_boundary_reg = regs[2];
  assign mode_control_reg = regs[3];
  assign io_control_reg = regs[4];

  // block base is relocation field times 64 inside the low 256 addresses
  assign io_block_base_out = {io_control_reg[sysctl_pkg::IO_RELOC_HI_BIT],
                              io_control_reg[sysctl_pkg::IO_RELOC_LO_BIT], 6'h00};
  // upper address byte must be zero, so relocation never leaves page zero
  assign in_block = (io_addr_in[15:8] == 8'h00) &&
                    (io_addr_in[7:6] == io_block_base_out[7:6]);
  assign local_ofs = {2'b00, io_addr_in[5:0] & sysctl_pkg::IO_LOCAL_MASK};

  genvar gi;
  generate
    for (gi = 0; gi < sysctl_pkg::NUM_REGS; gi++) begin : g_reg
      assign wr_sel[gi] = io_wr_in && in_block && (local_ofs == reg_ofs[gi]);
      reg_word #(
        .RESET_VAL(gi == 0 ? sysctl_pkg::RST_COMMON_BASE :
                   gi == 1 ? sysctl_pkg::RST_BANK_BASE :
                   gi == 2 ? sysctl_pkg::RST_AREA_BOUNDARY :
                   gi == 3 ? sysctl_pkg::RST_MODE_CONTROL : sysctl_pkg::RST_IO_CONTROL)
      ) u_reg (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .wr_in(wr_sel[gi]),
        .data_in(io_wdata_in),
        .q_out(regs[gi])
      );
      // per register: reset value, write landing, holding and read return
      reg_reset_a: assert property (@(posedge clk_sys_in)
        !nrst_in
        |=> regs[gi] == reg_rst[gi])
        else $error("register reset value wrong");
      reg_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        wr_sel[gi]
        |=> regs[gi] == $past(io_wdata_in))
        else $error("register write lost");
      reg_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !wr_sel[gi]
        |=> $stable(regs[gi]))
        else $error("register changed without write");
      reg_read_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        io_rd_in && in_block && local_ofs == reg_ofs[gi]
        |=> io_rdata_out == $past(regs[gi]))
        else $error("read data not the register value");
    end
  endgenerate

  assign page = log_addr_in[15:12];
  assign common1_start = area_boundary_reg[sysctl_pkg::COMMON1_START_HI:
                                           sysctl_pkg::COMMON1_START_LO];
  assign bank_start = area_boundary_reg[sysctl_pkg::BANK_START_HI:
                                        sysctl_pkg::BANK_START_LO];
  assign marker_en = mode_control_reg[sysctl_pkg::MARKER_ENABLE_BIT];

  always_comb begin
    st_nxt = st_r;
    // classification: boundary page belongs to the region starting there
    if (page >= common1_start) begin
      st_nxt.area = sysctl_pkg::AREA_COMMON1;
    end else if (page >= bank_start) begin
      st_nxt.area = sysctl_pkg::AREA_BANK;
    end else begin
      st_nxt.area = sysctl_pkg::AREA_COMMON0;
    end
    unique case (st_nxt.area)
      sysctl_pkg::AREA_COMMON1: sel_base = common_base_reg;
      sysctl_pkg::AREA_BANK: sel_base = bank_base_reg;
      default: sel_base = 8'h00;
    endcase
    st_nxt.phys = {4'h0, log_addr_in} + {sel_base, 12'h000};
    st_nxt.hit = (io_rd_in || io_wr_in) && in_block && (|wr_sel_any(local_ofs));
    st_nxt.rdata = 8'h00;
    for (int i = 0; i < sysctl_pkg::NUM_REGS; i++) begin
      if (io_rd_in && in_block && local_ofs == reg_ofs[i]) begin
        st_nxt.rdata = regs[i];
      end
    end
    // return-from-interrupt sequencing
    unique case (st_r.fetch)
      sysctl_pkg::FETCH_IDLE: begin
        if (return_from_interrupt_instr_fetched_in) begin
          st_nxt.fetch = marker_en ? sysctl_pkg::FETCH_IDLE : sysctl_pkg::FETCH_NORMAL;
        end
      end
      sysctl_pkg::FETCH_NORMAL: st_nxt.fetch = sysctl_pkg::FETCH_LEGACY;
      sysctl_pkg::FETCH_LEGACY: st_nxt.fetch = sysctl_pkg::FETCH_IDLE;
      default: st_nxt.fetch = sysctl_pkg::FETCH_IDLE;
    endcase
    if (marker_en) begin
      st_nxt.marker_n = !(opcode_fetch_in || irq0_ack_in || nmi_ack_first_in);
    end else begin
      // with marker off only the legacy refetch and acknowledges pull it low
      st_nxt.marker_n = !(irq0_ack_in || nmi_ack_first_in ||
                          st_nxt.fetch == sysctl_pkg::FETCH_LEGACY);
    end
  end

  function automatic logic wr_sel_any(input logic [7:0] ofs);
    logic r;
    r = 1'b0;
    for (int i = 0; i < sysctl_pkg::NUM_REGS; i++) begin
      if (ofs == reg_ofs[i]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_r <= '{rdata: 8'h00, hit: 1'b0, phys: 20'h00000,
                area: sysctl_pkg::AREA_COMMON0, marker_n: 1'b1,
                fetch: sysctl_pkg::FETCH_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata_out = st_r.rdata;
  assign io_hit_out = st_r.hit;
  assign phys_addr_out = st_r.phys;
  assign area_out = st_r.area;
  assign cycle_marker_out_n = st_r.marker_n;
  assign return_from_interrupt_instr_refetch_out = (st_r.fetch == sysctl_pkg::FETCH_LEGACY);
  assign io_halt_mode_out = io_control_reg[sysctl_pkg::IO_HALT_BIT];

  bank_reset_a: assert property (@(posedge clk_sys_in) !nrst_in |=> bank_base_reg == 8'h00)
    else $error("bank base not cleared by reset");
  bound_reset_a: assert property (@(posedge clk_sys_in) !nrst_in |=> area_boundary_reg == 8'hFF)
    else $error("boundaries not all ones after reset");
  marker_reset_a: assert property (@(posedge clk_sys_in) !nrst_in |=> marker_en)
    else $error("marker enable not set by reset");
  reloc_reset_a: assert property (@(posedge clk_sys_in) !nrst_in |=> io_block_base_out == 8'h00)
    else $error("relocation not cleared by reset");
  fetch_marker_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    marker_en && opcode_fetch_in |=> !cycle_marker_out_n)
    else $error("marker not low on fetch");
  no_marker_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !marker_en && !irq0_ack_in && !nmi_ack_first_in && st_r.fetch == sysctl_pkg::FETCH_IDLE
    && $stable(mode_control_reg) |=> cycle_marker_out_n)
    else $error("marker low while disabled");
  legacy_seq_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st_r.fetch == sysctl_pkg::FETCH_IDLE && return_from_interrupt_instr_fetched_in && !marker_en
    |=> ##1 return_from_interrupt_instr_refetch_out && !cycle_marker_out_n)
    else $error("legacy refetch missing");
  single_fetch_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st_r.fetch == sysctl_pkg::FETCH_IDLE && return_from_interrupt_instr_fetched_in && marker_en
    |=> ##1 !return_from_interrupt_instr_refetch_out)
    else $error("refetch with marker enabled");
  io_upper_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (io_rd_in || io_wr_in) && io_addr_in[15:8] != 8'h00 |=> !io_hit_out)
    else $error("decode with nonzero upper byte");
  area_c1_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    log_addr_in[15:12] >= area_boundary_reg[7:4] && $stable(common_base_reg)
    |=> area_out == sysctl_pkg::AREA_COMMON1 &&
        phys_addr_out == {4'h0, $past(log_addr_in)} + {common_base_reg, 12'h000})
    else $error("common area 1 mapping wrong");

  // i/o decode: refused or absent accesses answer with zero data and no hit, register accesses hit
  rdata_idle_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !io_rd_in
    |=> io_rdata_out == 8'h00)
    else $error("read data not zero when idle");
  rdata_upper_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    io_rd_in && io_addr_in[15:8] != 8'h00
    |=> io_rdata_out == 8'h00)
    else $error("read data with nonzero upper byte");
  hit_slot_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (io_rd_in || io_wr_in) && io_addr_in[7:6] != io_block_base_out[7:6]
    |=> !io_hit_out)
    else $error("hit outside relocated block");
  hit_idle_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !io_rd_in && !io_wr_in
    |=> !io_hit_out)
    else $error("hit without access");
  hit_ctrl_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    io_rd_in && in_block && local_ofs == sysctl_pkg::OFS_IO_CONTROL
    |=> io_hit_out)
    else $error("no hit on i/o control read");
  hit_bank_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    io_wr_in && in_block && local_ofs == sysctl_pkg::OFS_BANK_BASE
    |=> io_hit_out)
    else $error("no hit on bank base write");

  // mapping: region choice and address forming
  area_c0_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    page < bank_start && page < common1_start
    |=> area_out == sysctl_pkg::AREA_COMMON0 && phys_addr_out == {4'h0, $past(log_addr_in)})
    else $error("common area 0 mapping wrong");
  area_bank_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    page >= bank_start && page < common1_start
    |=> area_out == sysctl_pkg::AREA_BANK &&
        phys_addr_out == {4'h0, $past(log_addr_in)} + {$past(bank_base_reg), 12'h000})
    else $error("bank area mapping wrong");
  area_top_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    page >= common1_start
    |=> area_out == sysctl_pkg::AREA_COMMON1)
    else $error("boundary page not in common area 1");
  area_onehot_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    1'b1
    |-> $onehot(area_out))
    else $error("area code not one-hot");
  page_offset_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    1'b1
    |=> phys_addr_out[11:0] == $past(log_addr_in[11:0]))
    else $error("offset inside 4 KB page altered");
  c0_top_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    area_out == sysctl_pkg::AREA_COMMON0
    |-> phys_addr_out[19:16] == 4'h0)
    else $error("common area 0 given a base");

  // cycle marker and return-from-interrupt sequencing
  marker_irq_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    irq0_ack_in
    |=> !cycle_marker_out_n)
    else $error("marker not low on irq0 acknowledge");
  marker_nmi_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    nmi_ack_first_in
    |=> !cycle_marker_out_n)
    else $error("marker not low on nmi first cycle");
  marker_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    marker_en && !opcode_fetch_in && !irq0_ack_in && !nmi_ack_first_in
    |=> cycle_marker_out_n)
    else $error("marker low without cause");
  fetch_off_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !marker_en && opcode_fetch_in && !irq0_ack_in && !nmi_ack_first_in &&
    st_r.fetch != sysctl_pkg::FETCH_NORMAL
    |=> cycle_marker_out_n)
    else $error("marker low on fetch while disabled");
  refetch_once_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    return_from_interrupt_instr_refetch_out
    |=> !return_from_interrupt_instr_refetch_out)
    else $error("refetch longer than one cycle");
  refetch_follow_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st_r.fetch == sysctl_pkg::FETCH_NORMAL
    |=> return_from_interrupt_instr_refetch_out)
    else $error("refetch does not follow normal fetch");
  refetch_marker_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    return_from_interrupt_instr_refetch_out && !$past(marker_en)
    |-> !cycle_marker_out_n)
    else $error("legacy refetch without marker");
  fetch_onehot_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    1'b1
    |-> $onehot(st_r.fetch))
    else $error("fetch state not one-hot");

  // control fields follow their writes
  halt_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    wr_sel[4]
    |=> io_halt_mode_out == $past(io_wdata_in[sysctl_pkg::IO_HALT_BIT]))
    else $error("halt bit not written");
  halt_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !wr_sel[4]
    |=> $stable(io_halt_mode_out))
    else $error("halt mode changed without write");
  reloc_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    wr_sel[4]
    |=> io_block_base_out == {$past(io_wdata_in[7:6]), 6'h00})
    else $error("relocation base not written");
  mode_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    wr_sel[3]
    |=> marker_en == $past(io_wdata_in[sysctl_pkg::MARKER_ENABLE_BIT]))
    else $error("marker enable not written");
  bound_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    wr_sel[2]
    |=> common1_start == $past(io_wdata_in[7:4]) && bank_start == $past(io_wdata_in[3:0]))
    else $error("boundary nibbles not written");
endmodule
`default_nettype wire

// file: sim/bus_partner.sv
// bus-side partner: an old-style peripheral that counts cycles with the marker low
`timescale 1ns/1ns
`default_nettype none
module bus_partner (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic cycle_marker_in_n,
  output logic [7:0] marker_cnt_out
);
  // such peripherals decode return-from-interrupt only on marker-low cycles, so count them
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      marker_cnt_out <= 8'h00;
    end else if (cycle_marker_in_n === 1'b0) begin
      marker_cnt_out <= marker_cnt_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_sysctl_regs.sv
// self-checking bench for the system control registers
`timescale 1ns/1ns
`default_nettype none
module test_sysctl_regs;
  typedef struct packed {logic [15:0] la; logic [19:0] pa; logic [2:0] ar;} row_t;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [15:0] log_addr = 16'h0000;
  logic [2:0] cyc = 3'h0;
  logic return_from_interrupt_instr = 1'b0;
  logic [7:0] io_rdata_out, io_block_base_out, marker_cnt;
  logic [19:0] phys_addr_out;
  logic [2:0] area_out;
  logic io_hit_out, cycle_marker_out_n, return_from_interrupt_instr_refetch_out, io_halt_mode_out;
  int mismatches = 0;
  int n_compared = 0;
  row_t rows [5] = '{'{16'h3FFF, 20'h03FFF, 3'h1}, '{16'h4000, 20'h14000, 3'h2},
    '{16'hBFFF, 20'h1BFFF, 3'h2}, '{16'hC000, 20'h2C000, 3'h4}, '{16'hFFFF, 20'h2FFFF, 3'h4}};
  sysctl_regs sysctl_regs_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .io_addr_in(io_addr),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata_out),
    .io_hit_out(io_hit_out), .log_addr_in(log_addr), .phys_addr_out(phys_addr_out),
    .area_out(area_out), .opcode_fetch_in(cyc[0]), .irq0_ack_in(cyc[1]),
    .nmi_ack_first_in(cyc[2]), .return_from_interrupt_instr_fetched_in(return_from_interrupt_instr), .cycle_marker_out_n(cycle_marker_out_n),
    .return_from_interrupt_instr_refetch_out(return_from_interrupt_instr_refetch_out), .io_halt_mode_out(io_halt_mode_out),
    .io_block_base_out(io_block_base_out));
  bus_partner bus_partner_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .cycle_marker_in_n(cycle_marker_out_n), .marker_cnt_out(marker_cnt));
  always #25 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys_in);
    io_wr <= 1'b0;
    // let the written register settle before a caller looks at it
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_sys_in);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys_in);
    io_rd <= 1'b0;
    #1;
    chk({12'h000, io_rdata_out}, {12'h000, e});
    chk({19'h0, io_hit_out}, {19'h0, h});
  endtask
  // one fetch-type pulse, then count marker-low cycles and refetch strobes in a short window
  task automatic fire(input logic [2:0] c, input logic r, input int em, input int er);
    logic [7:0] c0;
    int nref;
    c0 = marker_cnt;
    nref = 0;
    @(posedge clk_sys_in);
    cyc <= c;
    return_from_interrupt_instr <= r;
    @(posedge clk_sys_in);
    cyc <= 3'h0;
    return_from_interrupt_instr <= 1'b0;
    repeat (6) begin
      @(posedge clk_sys_in);
      #1;
      if (return_from_interrupt_instr_refetch_out === 1'b1) nref++;
    end
    chk({12'h000, marker_cnt - c0}, 20'(em));
    chk(20'(nref), 20'(er));
  endtask
  task automatic reset_chk;
    rd(16'h0038, 8'h00, 1'b1);
    rd(16'h0039, 8'h00, 1'b1);
    rd(16'h003A, 8'hFF, 1'b1);
    rd(16'h003E, 8'h80, 1'b1);
    rd(16'h003F, 8'h00, 1'b1);
    chk({19'h0, io_halt_mode_out}, 20'h00000);
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(4000 * 50);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    reset_chk();
    wr(16'h0039, 8'h10);
    wr(16'h003A, 8'hC4);
    wr(16'h0038, 8'h20);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys_in);
      log_addr <= rows[i].la;
      @(posedge clk_sys_in);
      #1;
      chk(phys_addr_out, rows[i].pa);
      chk({17'h0, area_out}, {17'h0, rows[i].ar});
    end
    for (int k = 0; k < 3; k++) fire(3'(1 << k), 1'b0, 1, 0);
    fire(3'h0, 1'b1, 0, 0);
    wr(16'h003E, 8'h00);
    fire(3'h1, 1'b0, 0, 0);
    fire(3'h0, 1'b1, 1, 1);
    // relocate to the second 64-byte slot and enter stop mode in one write
    wr(16'h003F, 8'h60);
    chk({12'h000, io_block_base_out}, 20'h00040);
    chk({19'h0, io_halt_mode_out}, 20'h00001);
    rd(16'h003F, 8'h00, 1'b0);
    rd(16'h007F, 8'h60, 1'b1);
    rd(16'h017F, 8'h00, 1'b0);
    rd(16'h0070, 8'h00, 1'b0);
    wr(16'h007F, 8'h00);
    chk({19'h0, io_halt_mode_out}, 20'h00000);
    wr(16'h003F, 8'hE0);
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    reset_chk();
    conclude();
  end
endmodule
`default_nettype wire
